// ### bench/bwsr_regs_tb_top.sv
// self-checking bench of the window and secondary status bank
// assumes read data one cycle after the strobe and flags one cycle after events
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
	n_mismatch++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module bwsr_regs_tb_top;
	logic                clk = 1'b0;
	logic                nrst = 1'b0;
	bwsr_pkg::bwsr_bus_s bus = '0;
	bwsr_pkg::bwsr_req_s req = '0;
	bwsr_pkg::bwsr_ev_s  ev;
	logic [15:0]         rdata;
	logic                parity_response_enable = 1'b0;
	logic                system_error_enable = 1'b0;
	logic                cap_unlock = 1'b0;
	logic                io_fwd, mem_fwd, irq, sent;
	logic                go = 1'b0;
	logic [1:0]          kind = 2'h0;
	logic [3:0]          gap = 4'h0;
	logic [17:0]         rq[$];
	logic [1:0]          fq[$];
	logic                rd_pend = 1'b0;
	logic                fw_pend = 1'b0;
	int                  n_mismatch = 0;
	int                  comparisons = 0;
	logic [17:0]         e;
	logic [1:0]          f;
	logic [15:0]         flg;
	logic [2:0]          msk;
	logic [3:0]          nb;
	logic [15:0]         mb;

	always #50 clk = ~clk;

	bwsr_regs dut (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .ev(ev),
		.parity_response_enable(parity_response_enable),
		.system_error_enable(system_error_enable), .cap_unlock(cap_unlock),
		.req(req), .io_fwd(io_fwd), .mem_fwd(mem_fwd), .irq(irq));
	bwsr_sec_link link (.clk(clk), .nrst(nrst), .go(go), .kind(kind),
		.gap(gap), .ev(ev), .sent(sent));

	// ----------------------------------------------------------------
	// drivers and result monitor
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= '{1'b0, 1'b1, a, d};
		req <= '0;
	endtask : wr
	// ci asks the monitor to check irq beside the read data
	task automatic rd(input logic [7:0] a, input logic [15:0] d,
			input logic ci = 1'b0, input logic iv = 1'b0);
		@(posedge clk);
		bus <= '{1'b1, 1'b0, a, 16'h0000};
		req <= '0;
		rq.push_back({ci, iv, d});
	endtask : rd
	task automatic look(input logic [15:0] ia, input logic [31:0] ma,
			input logic [1:0] x);
		@(posedge clk);
		bus <= '0;
		req <= '{1'b1, ia, 1'b1, ma};
		fq.push_back(x);
	endtask : look
	task automatic idle;
		@(posedge clk);
		bus <= '0;
		req <= '0;
	endtask : idle
	task automatic summarize;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize

	always @(posedge clk) begin
		if (rd_pend) begin
			e = (rq.size() > 0) ? rq.pop_front() : 18'h3FFFF;
			`CHK("rdata", e[15:0], rdata)
			if (e[17]) `CHK("irq", e[16], irq)
		end
		if (fw_pend) begin
			f = (fq.size() > 0) ? fq.pop_front() : 2'h3;
			`CHK("fwd", f, {io_fwd, mem_fwd})
		end
		rd_pend = bus.rd;
		fw_pend = req.io_req | req.mem_req;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(35));
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		rd(8'h1C, 16'h00F1);
		rd(8'h1D, 16'h0001);
		rd(8'h1E, 16'h0000);
		rd(8'h20, 16'hFFF0);
		rd(8'h22, 16'h0000);
		rd(8'h30, 16'h0000);
		rd(8'h31, 16'h0000, 1'b1, 1'b0);
		wr(8'h1D, 16'h00FF);
		rd(8'h1D, 16'h00F1);
		wr(8'h1C, 16'h00A0);
		rd(8'h1C, 16'h00A1);
		idle;
		cap_unlock <= 1'b1;
		wr(8'h1C, 16'h0030);
		idle;
		cap_unlock <= 1'b0;
		rd(8'h1D, 16'h00F0);
		nb = 4'($urandom);
		wr(8'h1D, {8'h00, nb, 4'hF});
		rd(8'h1D, {8'h00, nb, 4'h0});
		mb = 16'($urandom);
		wr(8'h20, mb);
		rd(8'h20, {mb[15:4], 4'h0});
		wr(8'h40, 16'hFFFF);
		rd(8'h40, 16'h0000);
		wr(8'h1E, 16'h3EFF);
		rd(8'h1E, 16'h0000);
		wr(8'h1C, 16'h0020);
		wr(8'h1D, 16'h0050);
		wr(8'h20, 16'h1000);
		wr(8'h22, 16'h1FF0);
		look(16'h1FFF, 32'h0FFF_FFFF, 2'b00);
		look(16'h2000, 32'h1000_0000, 2'b11);
		look(16'h5FFF, 32'h1FFF_FFFF, 2'b11);
		look(16'h6000, 32'h2000_0000, 2'b00);
		wr(8'h1C, 16'h0060);
		wr(8'h20, 16'h2000);
		look(16'h6FFF, 32'h2000_0000, 2'b00);
		// each kind twice, enables off then on
		for (int i = 0; i < 8; i++) begin
			msk = 3'($urandom);
			wr(8'h31, {13'h0, msk});
			@(posedge clk);
			bus <= '0;
			go <= 1'b1;
			kind <= i[1:0];
			gap <= 4'($urandom % 5);
			parity_response_enable <= i[2];
			system_error_enable <= i[2];
			@(posedge clk);
			go <= 1'b0;
			for (int n = 0; n < 20 && !sent; n++) @(posedge clk);
			if (!sent) begin
				n_mismatch++;
				summarize();
			end
			flg = 16'h0000;
			if (i[1] == 1'b0) flg[8] = i[2];
			if (i[1:0] == 2'h2) flg[14] = i[2];
			if (i[1:0] == 2'h3) flg[15] = 1'b1;
			wr(8'h1E, 16'h0000);
			rd(8'h1E, flg);
			rd(8'h31, {13'h0, msk}, 1'b1,
				|({flg[15], flg[14], flg[8]} & msk));
			rd(8'h30, {13'h0, flg[15], flg[14], flg[8]});
			idle;
			rd(8'h30, 16'h0000);
			wr(8'h1E, flg);
			rd(8'h1E, 16'h0000);
		end
		// clear and poisoned packet in one cycle: the event must win
		@(posedge clk);
		bus <= '0;
		go <= 1'b1;
		kind <= 2'h3;
		gap <= 4'h0;
		@(posedge clk);
		go <= 1'b0;
		bus <= '{1'b0, 1'b1, 8'h1E, 16'h8000};
		idle;
		rd(8'h1E, 16'h8000);
		wr(8'h1E, 16'h8000);
		rd(8'h1E, 16'h0000);
		rd(8'h30, 16'h0004);
		repeat (3) idle;
		`CHK("queue", 0, rq.size() + fq.size())
		summarize();
	end
endmodule : bwsr_regs_tb_top
`default_nettype wire

// ### bench/bwsr_sec_link.sv
// secondary link traffic model: one poisoned packet or error message per go
// assumes go is a one-cycle pulse given while the model is idle
`timescale 1ns/1ps
`default_nettype none
module bwsr_sec_link (
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          go,
	input  wire logic [1:0]    kind,
	input  wire logic [3:0]    gap,
	output var bwsr_pkg::bwsr_ev_s ev,
	output var logic           sent
);
	logic       busy = 1'b0;
	logic [3:0] cnt  = 4'h0;
	logic [1:0] k    = 2'h0;
	always @(posedge clk) begin
		if (!nrst) begin
			busy <= 1'b0;
		end else if (go && !busy) begin
			busy <= 1'b1;
			cnt  <= gap;
			k    <= kind;
		end else if (busy) begin
			busy <= (cnt != 4'h0);
			cnt  <= cnt - 4'h1;
		end
	end
	// a gap lets the event land late, as a slow link would deliver it
	assign sent = busy && (cnt == 4'h0);
	assign ev   = sent ? bwsr_pkg::bwsr_ev_s'(4'h8 >> k) : '0;
endmodule : bwsr_sec_link
`default_nettype wire

// ### include/bwsr_pkg.sv
// constants and carrier types of the bridge window and secondary status bank
// assumes a byte-addressed configuration port with 16-bit data
//
// Function
// - io limit bit 0 is read-only and mirrors the io base capability bit
// - io limit bits 7:4 read-write, reset zero, top io address bits 15:12
// - io base and limit decide which io transactions are forwarded
// - memory base bits 15:4 read-write, reset 0xFFF, address bits 31:20
// - abort flags and timing field of secondary status read as zero
// - master parity flag sets on poisoned completion or write, only if enabled
// - system error flag sets on fatal or nonfatal message, only if enabled
// - parity error flag sets on any poisoned packet, enable ignored; here only poison_tlp sets it, not poison_cpl or poison_wr
// - the three error flags reset to zero, cleared by writing one
// - io base bits 7:4 hold lowest io address bits 15:12, reset 0xF
// - memory limit bits 15:4 hold highest memory address bits 31:20
package bwsr_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_IO_BASE   = 8'h1C;
	localparam logic [7:0] OFF_IO_LIMIT  = 8'h1D;
	localparam logic [7:0] OFF_SEC_STS   = 8'h1E;
	localparam logic [7:0] OFF_MEM_BASE  = 8'h20;
	localparam logic [7:0] OFF_MEM_LIMIT = 8'h22;
	localparam logic [7:0] OFF_IRQ_STS   = 8'h30;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h31;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CAP_BIT   = 0;
	localparam int FIELD_LO  = 4;
	localparam int MPF_BIT   = 8;
	localparam int RSE_BIT   = 14;
	localparam int DPE_BIT   = 15;
	localparam int IRQ_N     = 3;
	localparam int IRQ_MPF   = 0;
	localparam int IRQ_RSE   = 1;
	localparam int IRQ_DPE   = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic        IO_CAP_RST    = 1'h1;
	localparam logic [3:0]  IO_BASE_RST   = 4'hF;
	localparam logic [3:0]  IO_LIMIT_RST  = 4'h0;
	localparam logic [11:0] MEM_BASE_RST  = 12'hFFF;
	localparam logic [11:0] MEM_LIMIT_RST = 12'h000;
	localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} bwsr_bus_s;

	typedef struct packed {
		logic poison_cpl;
		logic poison_wr;
		logic err_msg;
		logic poison_tlp;
	} bwsr_ev_s;

	typedef struct packed {
		logic        io_req;
		logic [15:0] io_addr;
		logic        mem_req;
		logic [31:0] mem_addr;
	} bwsr_req_s;

endpackage : bwsr_pkg

// ### logic/bwsr_flag.sv
// one sticky event flag, set by hardware, cleared by a one-cycle clear
// assumes set and clear are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module bwsr_flag (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic set,
	input  wire logic clr,
	output logic      q
);
	typedef struct packed {
		logic q;
	} bwsr_flag_s;

	bwsr_flag_s st;
	bwsr_flag_s next_st;

	// set wins so an event in the clearing cycle is kept
	always_comb begin
		next_st = st;
		next_st.q = set | (st.q & ~clr);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q = st.q;

	property p_flag_set_wins;
		@(posedge clk) disable iff (!nrst) set |=> q;
	endproperty
	a_flag_set_wins: assert property (p_flag_set_wins)
		else $error("flag lost a set");
endmodule : bwsr_flag
`default_nettype wire

// ### logic/bwsr_regs.sv
// bridge io and memory window registers with secondary status flags
// assumes a configuration port with one-cycle strobes, read data next cycle,
// and event pulses plus enables from the rest of the port
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module bwsr_regs (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire bwsr_pkg::bwsr_bus_s bus,
	output logic [15:0]             rdata,
	input  wire bwsr_pkg::bwsr_ev_s  ev,
	input  wire logic               parity_response_enable,
	input  wire logic               system_error_enable,
	input  wire logic               cap_unlock,
	input  wire bwsr_pkg::bwsr_req_s req,
	output logic                    io_fwd,
	output logic                    mem_fwd,
	output logic                    irq
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        io_width_capability;
		logic [3:0]  io_window_base_field;
		logic [3:0]  io_window_limit_field;
		logic [11:0] memory_window_base_field;
		logic [11:0] memory_window_limit_field;
		logic [2:0]  irq_mask;
		logic [15:0] rdata;
	} bwsr_regs_s;

	localparam bwsr_regs_s RST = '{
		io_width_capability       : bwsr_pkg::IO_CAP_RST,
		io_window_base_field      : bwsr_pkg::IO_BASE_RST,
		io_window_limit_field     : bwsr_pkg::IO_LIMIT_RST,
		memory_window_base_field  : bwsr_pkg::MEM_BASE_RST,
		memory_window_limit_field : bwsr_pkg::MEM_LIMIT_RST,
		irq_mask                  : bwsr_pkg::IRQ_MASK_RST,
		rdata                     : 16'h0000
	};

	bwsr_regs_s st;
	bwsr_regs_s next_st;

	logic                         wr_io_base;
	logic                         wr_io_limit;
	logic                         wr_sec;
	logic                         wr_mem_base;
	logic                         wr_mem_limit;
	logic                         wr_mask;
	logic                         rd_irq;
	logic                         set_mpf;
	logic                         set_rse;
	logic                         set_dpe;
	logic                         master_parity_flag;
	logic                         got_system_error_flag;
	logic                         seen_parity_error_flag;
	logic [bwsr_pkg::IRQ_N-1:0]   irq_set;
	logic [bwsr_pkg::IRQ_N-1:0]   irq_sts;
	logic [15:0]                  secondary_side_status;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	assign wr_io_base   = bus.wr && bus.addr == bwsr_pkg::OFF_IO_BASE;
	assign wr_io_limit  = bus.wr && bus.addr == bwsr_pkg::OFF_IO_LIMIT;
	assign wr_sec       = bus.wr && bus.addr == bwsr_pkg::OFF_SEC_STS;
	assign wr_mem_base  = bus.wr && bus.addr == bwsr_pkg::OFF_MEM_BASE;
	assign wr_mem_limit = bus.wr && bus.addr == bwsr_pkg::OFF_MEM_LIMIT;
	assign wr_mask      = bus.wr && bus.addr == bwsr_pkg::OFF_IRQ_MASK;
	assign rd_irq       = bus.rd && bus.addr == bwsr_pkg::OFF_IRQ_STS;

	// ----------------------------------------------------------------
	// secondary status flags
	// ----------------------------------------------------------------
	assign set_mpf = parity_response_enable
		&& (ev.poison_cpl || ev.poison_wr);
	assign set_rse = system_error_enable && ev.err_msg;
	assign set_dpe = ev.poison_tlp;

	bwsr_flag u_mpf (
		.clk  (clk),
		.nrst (nrst),
		.set  (set_mpf),
		.clr  (wr_sec && bus.wdata[bwsr_pkg::MPF_BIT]),
		.q    (master_parity_flag)
	);

	bwsr_flag u_rse (
		.clk  (clk),
		.nrst (nrst),
		.set  (set_rse),
		.clr  (wr_sec && bus.wdata[bwsr_pkg::RSE_BIT]),
		.q    (got_system_error_flag)
	);

	bwsr_flag u_dpe (
		.clk  (clk),
		.nrst (nrst),
		.set  (set_dpe),
		.clr  (wr_sec && bus.wdata[bwsr_pkg::DPE_BIT]),
		.q    (seen_parity_error_flag)
	);

	// aborts and timing select never set in this bridge
	always_comb begin
		secondary_side_status = 16'h0000;
		secondary_side_status[bwsr_pkg::MPF_BIT] = master_parity_flag;
		secondary_side_status[bwsr_pkg::RSE_BIT] = got_system_error_flag;
		secondary_side_status[bwsr_pkg::DPE_BIT] = seen_parity_error_flag;
	end

	// ----------------------------------------------------------------
	// interrupt status, cleared by reading it
	// ----------------------------------------------------------------
	assign irq_set[bwsr_pkg::IRQ_MPF] = set_mpf;
	assign irq_set[bwsr_pkg::IRQ_RSE] = set_rse;
	assign irq_set[bwsr_pkg::IRQ_DPE] = set_dpe;

	for (genvar i = 0; i < bwsr_pkg::IRQ_N; i++) begin : g_irq
		bwsr_flag u_irq (
			.clk  (clk),
			.nrst (nrst),
			.set  (irq_set[i]),
			.clr  (rd_irq),
			.q    (irq_sts[i])
		);
	end

	assign irq = |(irq_sts & st.irq_mask);

	// ----------------------------------------------------------------
	// register writes and read data
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		// capability is write-locked unless the port opens it
		if (wr_io_base && cap_unlock) begin
			next_st.io_width_capability = bus.wdata[bwsr_pkg::CAP_BIT];
		end
		if (wr_io_base) begin
			next_st.io_window_base_field =
				bus.wdata[bwsr_pkg::FIELD_LO +: 4];
		end
		if (wr_io_limit) begin
			next_st.io_window_limit_field =
				bus.wdata[bwsr_pkg::FIELD_LO +: 4];
		end
		if (wr_mem_base) begin
			next_st.memory_window_base_field =
				bus.wdata[bwsr_pkg::FIELD_LO +: 12];
		end
		if (wr_mem_limit) begin
			next_st.memory_window_limit_field =
				bus.wdata[bwsr_pkg::FIELD_LO +: 12];
		end
		if (wr_mask) begin
			next_st.irq_mask = bus.wdata[bwsr_pkg::IRQ_N-1:0];
		end
		next_st.rdata = 16'h0000;
		if (bus.rd) begin
			case (bus.addr)
				bwsr_pkg::OFF_IO_BASE: begin
					next_st.rdata = {8'h00, st.io_window_base_field,
						3'h0, st.io_width_capability};
				end
				bwsr_pkg::OFF_IO_LIMIT: begin
					next_st.rdata = {8'h00, st.io_window_limit_field,
						3'h0, st.io_width_capability};
				end
				bwsr_pkg::OFF_SEC_STS: begin
					next_st.rdata = secondary_side_status;
				end
				bwsr_pkg::OFF_MEM_BASE: begin
					next_st.rdata = {st.memory_window_base_field, 4'h0};
				end
				bwsr_pkg::OFF_MEM_LIMIT: begin
					next_st.rdata = {st.memory_window_limit_field, 4'h0};
				end
				bwsr_pkg::OFF_IRQ_STS: begin
					next_st.rdata = {13'h0, irq_sts};
				end
				bwsr_pkg::OFF_IRQ_MASK: begin
					next_st.rdata = {13'h0, st.irq_mask};
				end
				default: begin
					next_st.rdata = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st <= RST;
		end else begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;

	// ----------------------------------------------------------------
	// forwarding windows
	// ----------------------------------------------------------------
	bwsr_window #(.W(4)) u_io_win (
		.clk   (clk),
		.nrst  (nrst),
		.req   (req.io_req),
		.addr  (req.io_addr[15:12]),
		.base  (st.io_window_base_field),
		.limit (st.io_window_limit_field),
		.hit   (io_fwd)
	);

	bwsr_window #(.W(12)) u_mem_win (
		.clk   (clk),
		.nrst  (nrst),
		.req   (req.mem_req),
		.addr  (req.mem_addr[31:20]),
		.base  (st.memory_window_base_field),
		.limit (st.memory_window_limit_field),
		.hit   (mem_fwd)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_cap_mirror;
		bus.rd && bus.addr == bwsr_pkg::OFF_IO_LIMIT
			|=> rdata[0] == $past(st.io_width_capability);
	endproperty
	a_cap_mirror: assert property (p_cap_mirror)
		else $error("io limit capability does not mirror base");

	property p_io_limit_wr;
		wr_io_limit ##1 (bus.rd && bus.addr == bwsr_pkg::OFF_IO_LIMIT)
			|=> rdata[7:4] == $past(bus.wdata[7:4], 2);
	endproperty
	a_io_limit_wr: assert property (p_io_limit_wr)
		else $error("io limit write not read back");

	property p_io_fwd;
		req.io_req |=> io_fwd == ($past(st.io_window_base_field)
			<= $past(req.io_addr[15:12]) && $past(req.io_addr[15:12])
			<= $past(st.io_window_limit_field));
	endproperty
	a_io_fwd: assert property (p_io_fwd)
		else $error("io forwarding decision wrong");

	property p_mem_base_wr;
		wr_mem_base |=> st.memory_window_base_field
			== $past(bus.wdata[15:4]);
	endproperty
	a_mem_base_wr: assert property (p_mem_base_wr)
		else $error("memory base write lost");

	property p_unused_zero;
		bus.rd && bus.addr == bwsr_pkg::OFF_SEC_STS
			|=> rdata[13:9] == 5'h0 && rdata[7:0] == 8'h00;
	endproperty
	a_unused_zero: assert property (p_unused_zero)
		else $error("unused status bits not zero");

	property p_mpf_gate;
		$rose(master_parity_flag) |-> $past(parity_response_enable)
			&& $past(ev.poison_cpl || ev.poison_wr);
	endproperty
	a_mpf_gate: assert property (p_mpf_gate)
		else $error("master parity flag set without cause");

	property p_rse_gate;
		$rose(got_system_error_flag)
			|-> $past(system_error_enable && ev.err_msg);
	endproperty
	a_rse_gate: assert property (p_rse_gate)
		else $error("system error flag set without cause");

	property p_dpe_set;
		ev.poison_tlp |=> seen_parity_error_flag ##1 1'b1;
	endproperty
	a_dpe_set: assert property (p_dpe_set)
		else $error("poisoned packet not flagged");

	property p_flag_clear;
		$fell(seen_parity_error_flag) |-> $past(wr_sec)
			&& $past(bus.wdata[15]) && !$past(ev.poison_tlp);
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("parity flag cleared without write of one");

	property p_empty_window;
		req.mem_req && st.memory_window_base_field
			> st.memory_window_limit_field |=> !mem_fwd;
	endproperty
	a_empty_window: assert property (p_empty_window)
		else $error("empty window forwarded");

	// a read-clear with no new event must drop the interrupt
	property p_irq_level;
		rd_irq && !(|irq_set) |=> !irq;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt level wrong");

	c_io_hit: cover property (req.io_req ##1 io_fwd);
	c_mem_hit: cover property (req.mem_req ##1 mem_fwd);
	c_set_clear: cover property (set_dpe && wr_sec && bus.wdata[15]);
	c_irq: cover property ($rose(irq));
endmodule : bwsr_regs
`default_nettype wire

// ### logic/bwsr_window.sv
// registered window hit for one address window
// assumes address, base and limit are the compared upper address bits
`timescale 1ns/1ps
`default_nettype none
module bwsr_window #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         req,
	input  wire logic [W-1:0] addr,
	input  wire logic [W-1:0] base,
	input  wire logic [W-1:0] limit,
	output logic              hit
);
	typedef struct packed {
		logic hit;
	} bwsr_win_s;

	bwsr_win_s st;
	bwsr_win_s next_st;

	// low address bits are implied zero at base, all ones at limit
	always_comb begin
		next_st = st;
		next_st.hit = req && (base <= limit)
			&& (addr >= base) && (addr <= limit);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign hit = st.hit;
endmodule : bwsr_window
`default_nettype wire
